// *** sfr_space_defs.svh ***
// Constants for the SFR space decoder and the system control register
// Summary of operation
// R1 - Map-select set steers SFR accesses to the mapped area, clear to standard.
// R2 - Only software writes change the map-select bit; hardware never alters it.
// R3 - Reserved system control bits read as zero; software writes zeros there.
// R4 - SFR addresses with low three bits zero support bit set, clear, test.
// R5 - Bit-addressable SFR portion provides 128 individually addressable bits.
// R6 - Reset loads system control bit 5 and bit 0 to one, bit 4 zero.
// R7 - System control holds map select bit 4, latch bit 5, xram map bit 0.
// R8 - All registers except PC and four register banks live in SFR space.
// R9 - SFRs occupy direct addresses 0x80 through 0xff.
`ifndef SFR_SPACE_DEFS_SVH
`define SFR_SPACE_DEFS_SVH

`define SYSCTL0_ADDR 8'h8f
`define SYSCTL0_RESET 8'h21
`define SYSCTL0_IMPL_MASK 8'h31
`define SYSCTL0_MAP_BIT 4
`define SYSCTL0_ALE_BIT 5
`define SYSCTL0_XMAP_BIT 0
`define SFR_SPACE_BIT 7
`define BIT_POS_W 3
`define SFR_BIT_COUNT 128

`endif

// *** sfr_space_pkg.sv ***
// Types shared by the SFR space decoder modules
package sfr_space_pkg;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_READ,
        ST_WRITE,
        ST_DONE
    } acc_state_e;

    typedef enum logic [1:0] {
        BIT_TEST,
        BIT_CLEAR,
        BIT_SET,
        BIT_NONE
    } bit_op_e;
endpackage

// *** sfr_dec_if.sv ***
// Decode request and result between the top and the address decoder
`timescale 1ns/100ps
interface sfr_dec_if;
    logic [7:0] addr;
    logic bit_mode;
    logic map_sel;
    logic sfr_hit;
    logic ctrl_hit;
    logic [7:0] byte_addr;
    logic [2:0] bit_pos;

    modport dec (
        input addr,
        input bit_mode,
        input map_sel,
        output sfr_hit,
        output ctrl_hit,
        output byte_addr,
        output bit_pos
    );
    modport user (
        output addr,
        output bit_mode,
        output map_sel,
        input sfr_hit,
        input ctrl_hit,
        input byte_addr,
        input bit_pos
    );
endinterface

// *** sfr_area_decode.sv ***
// Direct address decoder for byte and bit accesses to the SFR space
`timescale 1ns/100ps
`include "sfr_space_defs.svh"
module sfr_area_decode (
    sfr_dec_if.dec dif  // Decode request and result
);
    // Bit address to owning byte: low three bits select the bit
    function automatic logic [7:0] bit_byte(input logic [7:0] a);
        bit_byte = {a[7:`BIT_POS_W], 3'h0}; // R4
    endfunction

    function automatic logic is_sfr(input logic [7:0] a);
        is_sfr = a[`SFR_SPACE_BIT]; // R9
    endfunction

    logic [7:0] eff_addr;

    // 16 bit-addressable bytes of 8 bits give the full bit space
    assign eff_addr = dif.bit_mode ? bit_byte(dif.addr) : dif.addr; // R5
    assign dif.byte_addr = eff_addr;
    assign dif.bit_pos = dif.addr[`BIT_POS_W-1:0];
    assign dif.sfr_hit = is_sfr(eff_addr); // R8
    // Control register answers in both maps so software can always leave one
    assign dif.ctrl_hit = is_sfr(eff_addr) && !dif.bit_mode
        && (eff_addr == `SYSCTL0_ADDR);
endmodule

// *** sfr_space_map_select.sv ***
// SFR space access sequencer with system control register and map select
`timescale 1ns/100ps
`include "sfr_space_defs.svh"
module sfr_space_map_select (
    input wire logic SYS_CLK_I,         // System clock
    input wire logic RST_I,             // Synchronous reset, active high
    input wire logic [7:0] CPU_ADDR_I,  // Direct byte or bit address
    input wire logic CPU_RD_I,          // Byte read request
    input wire logic CPU_WR_I,          // Byte write request
    input wire logic CPU_BIT_I,         // Bit access request
    input wire logic [1:0] CPU_BIT_OP_I, // 0 test, 1 clear, 2 set
    input wire logic [7:0] CPU_WDATA_I, // Byte write data
    output logic [7:0] CPU_RDATA_O,     // Read data or tested bit in bit 0
    output logic CPU_ACK_O,             // Access complete pulse
    output logic CPU_BUSY_O,            // Sequencer not idle
    output logic STD_SEL_O,             // Standard area selected
    output logic MAP_SEL_O,             // Mapped area selected
    output logic [7:0] PER_ADDR_O,      // Peripheral byte address
    output logic [7:0] PER_WDATA_O,     // Peripheral write data
    output logic PER_RD_O,              // Peripheral read strobe
    output logic PER_WR_O,              // Peripheral write strobe
    input wire logic [7:0] STD_RDATA_I, // Standard area read data
    input wire logic [7:0] MAP_RDATA_I, // Mapped area read data
    output logic SFR_MAP_SELECT_O,      // Current map select bit
    output logic ADDRESS_LATCH_OUTPUT_CONTROL_O, // Latch output control bit
    output logic XRAM_MAP_CONTROL_O     // External RAM map control bit
);
    sfr_space_pkg::acc_state_e state_reg, state_next;
    sfr_space_pkg::bit_op_e op_reg, op_next;
    logic [7:0] system_control_zero_reg, system_control_zero_next;
    logic [7:0] addr_reg, addr_next;
    logic [7:0] data_reg, data_next;
    logic [2:0] pos_reg, pos_next;
    logic map_reg, map_next;
    logic sfr_reg, sfr_next;
    logic ctrl_reg, ctrl_next;
    logic [7:0] rd_byte;
    logic req;
    logic take;
    logic ctrl_wr;
    logic [7:0] rdata_reg, rdata_next;

    sfr_dec_if dif ();

    sfr_area_decode u_decode (
        .dif(dif)
    );

    assign dif.addr = CPU_ADDR_I;
    assign dif.bit_mode = CPU_BIT_I;
    assign dif.map_sel = system_control_zero_reg[`SYSCTL0_MAP_BIT];
    assign req = CPU_RD_I || CPU_WR_I || CPU_BIT_I;
    // Only the idle sequencer takes a request; one still held when it returns to idle is taken again
    assign take = (state_reg == sfr_space_pkg::ST_IDLE) && req;

    // Read source for the captured access
    always_comb begin
        if (ctrl_reg) begin
            rd_byte = system_control_zero_reg & `SYSCTL0_IMPL_MASK; // R3
        end else if (!sfr_reg) begin
            rd_byte = 8'h00;
        end else if (map_reg) begin
            rd_byte = MAP_RDATA_I; // R1
        end else begin
            rd_byte = STD_RDATA_I; // R1
        end
    end

    // Map is sampled per access, so a control write only steers
    // requests taken after its acknowledge
    always_comb begin
        addr_next = addr_reg;
        pos_next = pos_reg;
        map_next = map_reg;
        sfr_next = sfr_reg;
        ctrl_next = ctrl_reg;
        if (take) begin
            addr_next = dif.byte_addr;
            pos_next = dif.bit_pos;
            map_next = dif.map_sel; // R1
            sfr_next = dif.sfr_hit;
            ctrl_next = dif.ctrl_hit;
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            addr_reg <= 8'h00;
            pos_reg <= 3'h0;
            map_reg <= 1'b0;
            sfr_reg <= 1'b0;
            ctrl_reg <= 1'b0;
        end else begin
            addr_reg <= addr_next;
            pos_reg <= pos_next;
            map_reg <= map_next;
            sfr_reg <= sfr_next;
            ctrl_reg <= ctrl_next;
        end
    end

    always_comb begin
        state_next = state_reg;
        op_next = op_reg;
        data_next = data_reg;
        case (state_reg)
            sfr_space_pkg::ST_IDLE: begin
                if (take) begin
                    data_next = CPU_WDATA_I;
                    if (CPU_BIT_I) begin
                        op_next = sfr_space_pkg::bit_op_e'(CPU_BIT_OP_I);
                        state_next = sfr_space_pkg::ST_READ; // R4
                    end else if (CPU_WR_I) begin
                        op_next = sfr_space_pkg::BIT_NONE;
                        state_next = sfr_space_pkg::ST_WRITE;
                    end else begin
                        op_next = sfr_space_pkg::BIT_NONE;
                        state_next = sfr_space_pkg::ST_READ;
                    end
                end
            end
            sfr_space_pkg::ST_READ: begin
                case (op_reg)
                    sfr_space_pkg::BIT_TEST: begin
                        data_next = {7'h00, rd_byte[pos_reg]}; // R4
                        state_next = sfr_space_pkg::ST_DONE;
                    end
                    sfr_space_pkg::BIT_CLEAR: begin
                        data_next = rd_byte & ~(8'h01 << pos_reg); // R4
                        state_next = sfr_space_pkg::ST_WRITE;
                    end
                    sfr_space_pkg::BIT_SET: begin
                        data_next = rd_byte | (8'h01 << pos_reg); // R4
                        state_next = sfr_space_pkg::ST_WRITE;
                    end
                    default: begin
                        data_next = rd_byte;
                        state_next = sfr_space_pkg::ST_DONE;
                    end
                endcase
            end
            sfr_space_pkg::ST_WRITE: begin
                data_next = 8'h00;
                state_next = sfr_space_pkg::ST_IDLE;
            end
            sfr_space_pkg::ST_DONE: begin
                state_next = sfr_space_pkg::ST_IDLE;
            end
            default: begin
                state_next = sfr_space_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            state_reg <= sfr_space_pkg::ST_IDLE;
            op_reg <= sfr_space_pkg::BIT_NONE;
            data_reg <= 8'h00;
        end else begin
            state_reg <= state_next;
            op_reg <= op_next;
            data_reg <= data_next;
        end
    end

    // Only a software write reaches the map select bit
    assign ctrl_wr = (state_reg == sfr_space_pkg::ST_WRITE) && ctrl_reg;

    // Reserved bits are never stored, so they always read back as zero
    always_comb begin
        system_control_zero_next = system_control_zero_reg;
        if (ctrl_wr) begin
            system_control_zero_next =
                data_reg & `SYSCTL0_IMPL_MASK; // R2 R3 R7
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            system_control_zero_reg <= `SYSCTL0_RESET; // R6
        end else begin
            system_control_zero_reg <= system_control_zero_next;
        end
    end

    // Read result kept in a flip-flop for the acknowledge cycle only;
    // zero elsewhere so a stale byte never reaches the CPU
    always_comb begin
        rdata_next = 8'h00;
        if ((state_reg == sfr_space_pkg::ST_READ)
                && (state_next == sfr_space_pkg::ST_DONE)) begin
            rdata_next = data_next;
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    logic active;
    logic per_ok;
    assign active = (state_reg == sfr_space_pkg::ST_READ)
        || (state_reg == sfr_space_pkg::ST_WRITE);
    // Non-SFR and control accesses never disturb the peripheral areas
    assign per_ok = active && sfr_reg && !ctrl_reg;
    assign STD_SEL_O = per_ok && !map_reg; // R1
    assign MAP_SEL_O = per_ok && map_reg; // R1
    assign PER_RD_O = per_ok && (state_reg == sfr_space_pkg::ST_READ);
    assign PER_WR_O = per_ok && (state_reg == sfr_space_pkg::ST_WRITE);
    assign PER_ADDR_O = addr_reg;
    assign PER_WDATA_O = data_reg;
    assign CPU_ACK_O = (state_reg == sfr_space_pkg::ST_WRITE)
        || (state_reg == sfr_space_pkg::ST_DONE);
    assign CPU_BUSY_O = (state_reg != sfr_space_pkg::ST_IDLE);
    assign CPU_RDATA_O = rdata_reg;
    assign SFR_MAP_SELECT_O = system_control_zero_reg[`SYSCTL0_MAP_BIT]; // R7
    assign ADDRESS_LATCH_OUTPUT_CONTROL_O =
        system_control_zero_reg[`SYSCTL0_ALE_BIT]; // R7
    assign XRAM_MAP_CONTROL_O =
        system_control_zero_reg[`SYSCTL0_XMAP_BIT]; // R7
endmodule

// *** sfr_space_map_select_chk.sv ***
// Port-level assertions for the SFR space sequencer
`timescale 1ns/100ps
module sfr_space_map_select_chk (
    input wire logic SYS_CLK_I,
    input wire logic RST_I,
    input wire logic [7:0] CPU_ADDR_I,
    input wire logic CPU_RD_I,
    input wire logic CPU_WR_I,
    input wire logic CPU_BIT_I,
    input wire logic [1:0] CPU_BIT_OP_I,
    input wire logic [7:0] CPU_RDATA_O,
    input wire logic CPU_ACK_O,
    input wire logic CPU_BUSY_O,
    input wire logic STD_SEL_O,
    input wire logic MAP_SEL_O,
    input wire logic [7:0] PER_ADDR_O,
    input wire logic [7:0] PER_WDATA_O,
    input wire logic PER_RD_O,
    input wire logic PER_WR_O,
    input wire logic [7:0] STD_RDATA_I,
    input wire logic [7:0] MAP_RDATA_I,
    input wire logic SFR_MAP_SELECT_O,
    input wire logic ADDRESS_LATCH_OUTPUT_CONTROL_O,
    input wire logic XRAM_MAP_CONTROL_O
);
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (RST_I);
    logic go;
    logic rd_only;
    logic [7:0] a_reg;
    logic [7:0] a_next;
    logic [7:0] rd_d;
    logic [7:0] msk;
    assign go = !CPU_BUSY_O && (CPU_RD_I || CPU_WR_I || CPU_BIT_I);
    assign rd_only = go && !CPU_BIT_I && !CPU_WR_I;
    assign rd_d = MAP_SEL_O ? MAP_RDATA_I : STD_RDATA_I;
    assign msk = 8'h01 << a_reg[2:0];
    // Taken address, kept for the later strobe cycles
    always_comb a_next = go ? CPU_ADDR_I : a_reg;
    always_ff @(posedge SYS_CLK_I) a_reg <= a_next;
    map_steer_a: assert property (
        (PER_RD_O || PER_WR_O) |-> MAP_SEL_O == SFR_MAP_SELECT_O
        && STD_SEL_O == !MAP_SEL_O) else $error("wrong area selected");
    map_hold_a: assert property (
        $changed(SFR_MAP_SELECT_O) |-> CPU_ACK_O || $past(CPU_ACK_O)
        || $past(RST_I)) else $error("map bit moved without a write");
    ctrl_read_a: assert property (
        rd_only && CPU_ADDR_I == 8'h8f |-> ##2 CPU_ACK_O && CPU_RDATA_O ==
        {2'h0, ADDRESS_LATCH_OUTPUT_CONTROL_O, SFR_MAP_SELECT_O, 3'h0,
        XRAM_MAP_CONTROL_O}) else $error("control read data wrong");
    bit_set_a: assert property (
        go && CPU_BIT_I && CPU_BIT_OP_I == 2'h2 && CPU_ADDR_I[7] |=>
        PER_RD_O ##1 PER_WR_O && CPU_ACK_O && PER_ADDR_O == {a_reg[7:3],
        3'h0} && PER_WDATA_O == ($past(rd_d) | msk)) else $error("bit set");
    bit_clr_a: assert property (
        go && CPU_BIT_I && CPU_BIT_OP_I == 2'h1 && CPU_ADDR_I[7] |=>
        PER_RD_O ##1 PER_WR_O && PER_WDATA_O == ($past(rd_d) & ~msk))
        else $error("bit clear wrong");
    bit_low_a: assert property (
        go && CPU_BIT_I && !CPU_ADDR_I[7] |=> !PER_RD_O ##1 !PER_WR_O
        && CPU_ACK_O && CPU_RDATA_O == 8'h00) else $error("low bit access");
    byte_rd_a: assert property (
        rd_only && CPU_ADDR_I[7] && CPU_ADDR_I != 8'h8f |=> PER_RD_O ##1
        CPU_ACK_O && CPU_RDATA_O == $past(rd_d)) else $error("byte read");
    rst_val_a: assert property (
        $fell(RST_I) |-> ADDRESS_LATCH_OUTPUT_CONTROL_O && !SFR_MAP_SELECT_O
        && XRAM_MAP_CONTROL_O) else $error("control reset value wrong");
    cover property (go && CPU_BIT_I && CPU_ADDR_I[7]);
    cover property (PER_WR_O && MAP_SEL_O);
    cover property ($rose(SFR_MAP_SELECT_O));
endmodule
bind sfr_space_map_select sfr_space_map_select_chk chk_u (.*);

// *** sfr_area_model.sv ***
// Behavioural standard and mapped register areas
`timescale 1ns/100ps
module sfr_area_model (
    input wire logic clk_i, // Clock
    input wire logic std_i, // Standard area chosen
    input wire logic map_i, // Mapped area chosen
    input wire logic rd_i, // Read strobe
    input wire logic wr_i, // Write strobe
    input wire logic [7:0] addr_i, // Byte address
    input wire logic [7:0] wdata_i, // Write data
    output logic [7:0] std_o, // Standard read data
    output logic [7:0] map_o // Mapped read data
);
    logic [7:0] s_mem [256];
    logic [7:0] m_mem [256];
    initial begin
        for (int i = 0; i < 256; i++) begin
            s_mem[i] = 8'(i);
            m_mem[i] = 8'(i) ^ 8'h5a;
        end
    end
    // Unselected area shows inverted data so a wrong steer shows up
    assign std_o = (rd_i && std_i) ? s_mem[addr_i] : ~s_mem[addr_i];
    assign map_o = (rd_i && map_i) ? m_mem[addr_i] : ~m_mem[addr_i];
    always @(posedge clk_i) begin
        if (wr_i && std_i) s_mem[addr_i] <= wdata_i;
        if (wr_i && map_i) m_mem[addr_i] <= wdata_i;
    end
endmodule

// *** sfr_space_map_select_test.sv ***
// Self-checking bench for the SFR space sequencer
`timescale 1ns/100ps
module sfr_space_map_select_test;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdat = 8'h00;
    logic [2:0] req = 3'h0;
    logic [1:0] op = 2'h0;
    logic [7:0] rdat, paddr, pwdat, srd, mrd;
    logic ack, busy, ssel, msel, prd, pwr, mapb, aleb, xmb;
    int bad_count = 0;
    int compares = 0;
    always #2.5 clk = ~clk;
    sfr_space_map_select dut_u (.SYS_CLK_I(clk), .RST_I(rst),
        .CPU_ADDR_I(addr), .CPU_RD_I(req[0]), .CPU_WR_I(req[1]),
        .CPU_BIT_I(req[2]), .CPU_BIT_OP_I(op), .CPU_WDATA_I(wdat),
        .CPU_RDATA_O(rdat), .CPU_ACK_O(ack), .CPU_BUSY_O(busy),
        .STD_SEL_O(ssel), .MAP_SEL_O(msel), .PER_ADDR_O(paddr),
        .PER_WDATA_O(pwdat), .PER_RD_O(prd), .PER_WR_O(pwr),
        .STD_RDATA_I(srd), .MAP_RDATA_I(mrd), .SFR_MAP_SELECT_O(mapb),
        .ADDRESS_LATCH_OUTPUT_CONTROL_O(aleb), .XRAM_MAP_CONTROL_O(xmb));
    sfr_area_model area_u (.clk_i(clk), .std_i(ssel), .map_i(msel),
        .rd_i(prd), .wr_i(pwr), .addr_i(paddr), .wdata_i(pwdat),
        .std_o(srd), .map_o(mrd));
    task automatic chk(input string n, input logic [7:0] s, e);
        compares++;
        if (s !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    // Request held until the rising edge after the falling edge at which ack is seen high
    task automatic acc(input logic [2:0] k, input logic [1:0] o,
            input logic [7:0] a, w, output logic [7:0] r);
        int n;
        @(posedge clk);
        req <= k;
        op <= o;
        addr <= a;
        wdat <= w;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        r = rdat;
        chk("busy with ack", {7'h0, busy}, 8'h01);
        @(posedge clk);
        req <= 3'h0;
        // First pass of the loop is the idle cycle in which the request is taken
        chk("ack latency", 8'(n - 1), (k == 3'h2) ? 8'h01 : 8'h02);
    endtask
    task automatic t_reset;
        logic [7:0] r;
        chk("ctrl pins", {5'h0, aleb, mapb, xmb}, 8'h05);
        acc(3'h1, 2'h0, 8'h8f, 8'h00, r);
        chk("ctrl reset", r, 8'h21);
        $display("reset test done");
    endtask
    task automatic t_map;
        logic [7:0] r;
        acc(3'h2, 2'h0, 8'h8f, 8'h10, r);
        acc(3'h1, 2'h0, 8'h90, 8'h00, r);
        chk("mapped read", r, 8'h90 ^ 8'h5a);
        acc(3'h2, 2'h0, 8'hc8, 8'h3c, r);
        acc(3'h1, 2'h0, 8'h8f, 8'h00, r);
        chk("ctrl read", r, 8'h10);
        chk("map kept", {7'h0, mapb}, 8'h01);
        acc(3'h2, 2'h0, 8'h8f, 8'h00, r);
        acc(3'h1, 2'h0, 8'hc8, 8'h00, r);
        chk("std read", r, 8'hc8);
        acc(3'h1, 2'h0, 8'h8f, 8'h00, r);
        chk("ctrl cleared", r, 8'h00);
        acc(3'h2, 2'h0, 8'h8f, 8'h31, r);
        acc(3'h1, 2'h0, 8'hc8, 8'h00, r);
        chk("mapped write", r, 8'h3c);
        acc(3'h2, 2'h0, 8'h8f, 8'h21, r);
        $display("map test done");
    endtask
    task automatic t_bits;
        logic [7:0] r;
        for (int p = 0; p < 8; p++) begin
            acc(3'h4, 2'h1, 8'ha0 + 8'(p), 8'h00, r);
            acc(3'h4, 2'h0, 8'ha0 + 8'(p), 8'h00, r);
            chk("bit cleared", r, 8'h00);
            acc(3'h4, 2'h2, 8'ha0 + 8'(p), 8'h00, r);
            acc(3'h4, 2'h0, 8'ha0 + 8'(p), 8'h00, r);
            chk("bit set", r, 8'h01);
        end
        acc(3'h4, 2'h3, 8'ha3, 8'h00, r);
        chk("owning byte", r, 8'hff);
        acc(3'h4, 2'h0, 8'hff, 8'h00, r);
        chk("top bit", r, 8'h01);
        acc(3'h4, 2'h0, 8'h7f, 8'h00, r);
        chk("non sfr bit", r, 8'h00);
        $display("bit test done");
    endtask
    task automatic t_low;
        logic [7:0] r;
        acc(3'h2, 2'h0, 8'h20, 8'h55, r);
        acc(3'h1, 2'h0, 8'h20, 8'h00, r);
        chk("low read", r, 8'h00);
        acc(3'h1, 2'h0, 8'h80, 8'h00, r);
        chk("first sfr", r, 8'h80);
        $display("range test done");
    endtask
    task automatic complete_run;
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_map();
        t_bits();
        t_low();
        complete_run();
    end
    initial begin
        #20000;
        bad_count++;
        complete_run();
    end
endmodule
